/* analog_pd_defines.vh */
// constants for the analog power-down control block
`ifndef ANALOG_PD_DEFINES_VH
`define ANALOG_PD_DEFINES_VH

`define WAKE_POWER_STATE_ADDR 32'h40048234
`define RUN_POWER_STATE_ADDR  32'h40048238
`define PD_ADDR_WORD_LSB      2
`define PD_RESET_VALUE        16'hedf0
`define PD_REG_WIDTH          16
`define PD_CTRL_WIDTH         8
`define PD_RC_OUT_BIT         0
`define PD_RC_CORE_BIT        1
`define PD_NVM_BIT            2
`define PD_BROWNOUT_BIT       3
`define PD_CONVERTER_BIT      4
`define PD_CRYSTAL_BIT        5
`define PD_WATCHDOG_BIT       6
`define PD_PLL_BIT            7
`define PD_WAIT_WIDTH         4
`define PD_WAIT_STEP          4'h1

`endif

/* analog_power_down_control.v */
// apb register block driving the analog power-down controls
`timescale 1ns/1ps
`include "analog_pd_defines.vh"

module analog_power_down_control #(
  parameter STOP_WAIT = 2
) (
  // clock and synchronous active-low reset
  input  wire        mclk,
  input  wire        rst_n,
  // apb slave port
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // asynchronous pins, each input passes a two-stage synchroniser
  input  wire        wake_event,
  input  wire        rc_clk_stopped,
  output reg         rc_clk_stop_req,
  // analog controls, high powers the block down
  output wire        rc_osc_output_off,
  output reg         rc_osc_core_off,
  output wire        nvm_array_off,
  output wire        brownout_detector_off,
  output wire        converter_off,
  output wire        crystal_osc_off,
  output wire        watchdog_osc_off,
  output wire        system_pll_off
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  // apb word width; each register keeps only its low half
  localparam DATA_WIDTH = 32;
  localparam PAD_WIDTH  = DATA_WIDTH - `PD_REG_WIDTH;

  function is_addr;
    input [31:0] a;
    input [31:0] target;
    begin
      is_addr = (a[31:`PD_ADDR_WORD_LSB] == target[31:`PD_ADDR_WORD_LSB]);
    end
  endfunction

  wire acc      = psel & penable;
  wire hit_wake = is_addr(paddr, `WAKE_POWER_STATE_ADDR);
  wire hit_run  = is_addr(paddr, `RUN_POWER_STATE_ADDR);
  assign pready  = 1'b1;
  // no wait states: every register is a plain flop
  // unmapped addresses answer with an error and read zero
  assign pslverr = acc & ~(hit_wake | hit_run);

  ////////////////////////////////////////////////////////////////////////
  // registers and pin synchronisers
  reg [`PD_REG_WIDTH-1:0]  run_reg;
  reg [`PD_REG_WIDTH-1:0]  wake_reg;
  reg [`PD_REG_WIDTH-1:0]  run_next;
  reg [1:0]                wake_sync_reg;
  reg                      wake_seen_reg;
  reg [1:0]                stop_sync_reg;
  reg [`PD_WAIT_WIDTH-1:0] wait_reg;

  // only the second stage of each synchroniser is read by logic
  wire wake_pulse = wake_sync_reg[1] & ~wake_seen_reg;
  wire rc_stopped = stop_sync_reg[1];

  // write strobes, qualified by the access phase
  wire wr_run   = acc & pwrite & hit_run;
  wire wr_wake  = acc & pwrite & hit_wake;
  // read data is captured in setup so it stands for the whole access
  wire rd_setup = psel & ~penable & ~pwrite;

  // a wake load beats a run write in the same cycle; that write is lost
  always @* begin
    if (wake_pulse)
      run_next = wake_reg;
    else if (wr_run)
      run_next = pwdata[`PD_REG_WIDTH-1:0];
    else
      run_next = run_reg;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      run_reg       <= `PD_RESET_VALUE;
      wake_reg      <= `PD_RESET_VALUE;
      wake_sync_reg <= 2'h0;
      wake_seen_reg <= 1'b0;
      stop_sync_reg <= 2'h0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[0], wake_event};
      wake_seen_reg <= wake_sync_reg[1];
      stop_sync_reg <= {stop_sync_reg[0], rc_clk_stopped};
      run_reg       <= run_next;
      if (wr_wake)
        wake_reg <= pwdata[`PD_REG_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, upper half zero
  function [DATA_WIDTH-1:0] pad_word;
    input [`PD_REG_WIDTH-1:0] r;
    begin
      pad_word = {{PAD_WIDTH{1'b0}}, r};
    end
  endfunction

  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= {DATA_WIDTH{1'b0}};
    end else if (rd_setup) begin
      if (hit_run)
        prdata <= pad_word(run_reg);
      else if (hit_wake)
        prdata <= pad_word(wake_reg);
      else
        prdata <= {DATA_WIDTH{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // direct outputs
  // every control but the rc core follows the register with no delay
  assign rc_osc_output_off     = run_reg[`PD_RC_OUT_BIT];
  assign nvm_array_off         = run_reg[`PD_NVM_BIT];
  assign brownout_detector_off = run_reg[`PD_BROWNOUT_BIT];
  assign converter_off         = run_reg[`PD_CONVERTER_BIT];
  assign crystal_osc_off       = run_reg[`PD_CRYSTAL_BIT];
  assign watchdog_osc_off      = run_reg[`PD_WATCHDOG_BIT];
  assign system_pll_off        = run_reg[`PD_PLL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // rc core: stop the clock cleanly before cutting power
  // cutting power under a running clock could leave a runt pulse on it,
  // so power is cut only after the gate reports a clean stop; a gate
  // that never answers keeps the core powered, which is the safe side

  // state codes of the rc core power-down sequence
  localparam ST_ON   = 2'h0;
  localparam ST_STOP = 2'h1;
  localparam ST_OFF  = 2'h2;
  localparam [`PD_WAIT_WIDTH-1:0] STOP_WAIT_CNT =
    STOP_WAIT[`PD_WAIT_WIDTH-1:0];
  localparam [`PD_WAIT_WIDTH-1:0] WAIT_STEP = `PD_WAIT_STEP;

  reg [1:0]                state_reg;
  reg [1:0]                state_next;
  reg                      stop_req_next;
  reg                      core_off_next;
  reg [`PD_WAIT_WIDTH-1:0] wait_next;
  wire                     want_off = run_reg[`PD_RC_CORE_BIT];
  wire                     settled  = (wait_reg == STOP_WAIT_CNT);

  always @* begin
    state_next    = state_reg;
    stop_req_next = rc_clk_stop_req;
    core_off_next = rc_osc_core_off;
    wait_next     = wait_reg;
    case (state_reg)
      ST_ON: begin
        if (want_off) begin
          stop_req_next = 1'b1;
          wait_next     = {`PD_WAIT_WIDTH{1'b0}};
          state_next    = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!want_off) begin
          // software changed its mind before the core was powered down
          stop_req_next = 1'b0;
          state_next    = ST_ON;
        end else if (rc_stopped) begin
          if (settled) begin
            core_off_next = 1'b1;
            state_next    = ST_OFF;
          end else begin
            wait_next = wait_reg + WAIT_STEP;
          end
        end
      end
      ST_OFF: begin
        if (!want_off) begin
          // power returns and the clock is released in the same cycle
          core_off_next = 1'b0;
          stop_req_next = 1'b0;
          state_next    = ST_ON;
        end
      end
      default: begin
        state_next    = ST_ON;
        stop_req_next = 1'b0;
        core_off_next = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg       <= ST_ON;
      rc_clk_stop_req <= 1'b0;
      rc_osc_core_off <= 1'b0;
      wait_reg        <= {`PD_WAIT_WIDTH{1'b0}};
    end else begin
      state_reg       <= state_next;
      rc_clk_stop_req <= stop_req_next;
      rc_osc_core_off <= core_off_next;
      wait_reg        <= wait_next;
    end
  end

endmodule

/* pd_checker_assertions.sv */
// assertions for the analog power-down control block
`timescale 1ns/1ps
module pd_checker (
  input wire        mclk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire        pslverr,
  input wire        rc_clk_stopped,
  input wire        rc_clk_stop_req,
  input wire        rc_osc_core_off,
  input wire        rc_osc_output_off,
  input wire        nvm_array_off,
  input wire        system_pll_off,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire hit = paddr == 32'h40048234 || paddr == 32'h40048238;
  sequence run_wr; acc && pwrite && paddr == 32'h40048238; endsequence
  sequence stop_held; (rc_clk_stop_req && rc_clk_stopped) [*8]; endsequence
  a_no_wait: assert property (pready)
    else $error("pready low");
  a_good_addr: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  a_run_apply: assert property (run_wr |=> {system_pll_off, nvm_array_off,
    rc_osc_output_off} == {$past(pwdata[7]), $past(pwdata[2]),
    $past(pwdata[0])}) else $error("run write not applied");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_core_after: assert property ($rose(rc_osc_core_off) |->
    rc_clk_stop_req && $past(rc_clk_stopped, 3)) else $error("core off early");
  a_core_waits: assert property ($rose(rc_clk_stop_req) |->
    !rc_osc_core_off [*3]) else $error("core off before clock stop");
  a_core_bound: assert property (stop_held |-> rc_osc_core_off)
    else $error("core off never taken");
  a_core_clear: assert property (run_wr ##0 !pwdata[1] |-> ##[1:2]
    !rc_clk_stop_req && !rc_osc_core_off) else $error("core off not cleared");
endmodule
bind analog_power_down_control pd_checker chk (.*);

/* tb_top.sv */
// self-checking bench for the analog power-down control block
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        wake_event = 0, rc_clk_stopped = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, rc_clk_stop_req;
  wire  [7:0]  pd;
  int          n_mismatch = 0, checked = 0, n;
  localparam WAKE = 32'h40048234, RUN = 32'h40048238;
  always #10 mclk = ~mclk;
  analog_power_down_control DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wake_event(wake_event), .rc_clk_stopped(rc_clk_stopped),
    .rc_clk_stop_req(rc_clk_stop_req), .rc_osc_output_off(pd[0]),
    .rc_osc_core_off(pd[1]), .nvm_array_off(pd[2]),
    .brownout_detector_off(pd[3]), .converter_off(pd[4]),
    .crystal_osc_off(pd[5]), .watchdog_osc_off(pd[6]),
    .system_pll_off(pd[7]));
  //////////////////////////////////////////////////////////////////////////
  task cmp(input string nm, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d, input logic err);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    cmp("pslverr", err, pslverr);
    psel <= 0;
    penable <= 0;
  endtask
  task t_reset;
    apb(0, WAKE, 0, 0);
    cmp("wake reg", 32'hedf0, rd);
    apb(0, RUN, 0, 0);
    cmp("run reg", 32'hedf0, rd);
    cmp("pd out", 8'hf0, pd);
  endtask
  task t_run;
    apb(1, RUN, 32'hffffed5d, 0);
    @(negedge mclk);
    cmp("pd out", 8'h5d, pd);
    apb(0, RUN, 0, 0);
    cmp("run reg", 32'hed5d, rd);
    apb(1, RUN, 32'hedf0, 0);
    @(negedge mclk);
    cmp("pd out", 8'hf0, pd);
  endtask
  task t_rc;
    apb(1, RUN, 32'hedf2, 0);
    repeat (6) @(negedge mclk);
    cmp("stop req", 1, rc_clk_stop_req);
    cmp("core off", 0, pd[1]);
    @(posedge mclk);
    rc_clk_stopped <= 1;
    // 2 sync stages plus settle cycles, so a few edges at least
    for (n = 0; n < 20 && pd[1] !== 1'b1; n++) @(negedge mclk);
    cmp("core delay", 1, n >= 3 && n < 20);
    apb(1, RUN, 32'hedf0, 0);
    rc_clk_stopped <= 0;
    repeat (2) @(negedge mclk);
    cmp("stop req", 0, {rc_clk_stop_req, pd[1]});
  endtask
  task t_wake;
    apb(1, WAKE, 32'hed5c, 0);
    wake_event <= 1;
    repeat (6) @(posedge mclk);
    wake_event <= 0;
    apb(0, RUN, 0, 0);
    cmp("run reg", 32'hed5c, rd);
    cmp("pd out", 8'h5c, pd);
  endtask
  task t_bad;
    apb(1, 32'h4004823c, 32'hffff, 1);
    apb(0, 32'h40048230, 0, 1);
    cmp("bad read", 0, rd);
    apb(0, RUN, 0, 0);
    cmp("run reg", 32'hed5c, rd);
  endtask
  task finish_test;
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    t_reset;
    t_run;
    t_rc;
    t_wake;
    t_bad;
    finish_test;
  end
endmodule
